// ===== verilog/gsc_pkg.sv
// Constants for the gauge state and control command block.
// Assumes a single 25 MHz core clock shared by the SMBus layer and the gauge.
package gsc_pkg;

  // Core clock rate and time figures
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned PF_RETRY_S = 4;          // Lockout after a failed clear
  localparam int unsigned RESET_STRETCH_US = 2000; // Bus clock stretch on full reset
  localparam int unsigned PF_RETRY_CYCLES = PF_RETRY_S * CLK_HZ;
  localparam int unsigned RESET_STRETCH_CYCLES = (RESET_STRETCH_US * (CLK_HZ / 1_000_000));

  // Control words written to the manufacturer access command
  localparam logic [15:0] CMD_SHUTDOWN = 16'h0010;
  localparam logic [15:0] CMD_SLEEP = 16'h0011;
  localparam logic [15:0] CMD_TRACK_ENABLE = 16'h0021;
  localparam logic [15:0] CMD_PF_CLEAR_1 = 16'h2673;
  localparam logic [15:0] CMD_PF_CLEAR_2 = 16'h1712;
  localparam logic [15:0] CMD_FUSE_BLOW = 16'h0030;
  localparam logic [15:0] CMD_FUSE_RELEASE = 16'h0031;
  localparam logic [15:0] CMD_LEDS_ON = 16'h0032;
  localparam logic [15:0] CMD_LEDS_OFF = 16'h0033;
  localparam logic [15:0] CMD_DISPLAY_ON = 16'h0034;
  localparam logic [15:0] CMD_CALIBRATE = 16'h0040;
  localparam logic [15:0] CMD_FULL_RESET = 16'h0041;

  // Battery state codes
  localparam logic [3:0] ST_WAKE = 4'h0;
  localparam logic [3:0] ST_DISCHARGE = 4'h1;
  localparam logic [3:0] ST_PRECHARGE = 4'h3;
  localparam logic [3:0] ST_FAST_CHARGE = 4'h5;
  localparam logic [3:0] ST_MAINT_CHARGE = 4'h7;
  localparam logic [3:0] ST_CHARGE_FAULT = 4'h8;
  localparam logic [3:0] ST_PERM_FAIL = 4'h9;
  localparam logic [3:0] ST_DSG_OVERCURRENT = 4'ha;
  localparam logic [3:0] ST_CHG_OVERHEAT = 4'hb;
  localparam logic [3:0] ST_SHORT_FAIL = 4'hc;
  localparam logic [3:0] ST_SLEEP = 4'hd;
  localparam logic [3:0] ST_DEPLETED = 4'he;
  localparam logic [3:0] ST_REMOVED = 4'hf;

  // Manufacturer status word layout
  localparam logic [7:0] MFG_STATUS_LOW = 8'h02;

  // Register indices on the plain register port
  localparam int unsigned REG_AW = 4;
  localparam logic [3:0] REG_UPDATE_FLAGS = 4'h0;
  localparam logic [3:0] REG_MFG_STATUS = 4'h1;
  localparam logic [3:0] REG_CTRL_STATUS = 4'h2;
  localparam logic [3:0] REG_CTRL = 4'h3;

  // Field positions
  localparam int unsigned UPD_TRACK_BIT = 2;   // Tracking enable in update flags
  localparam logic [7:0] UPD_RESET = 8'h00;
  localparam int unsigned CTRL_CAL_EXIT_BIT = 0; // Write 1 to leave calibration
  localparam int unsigned CTRL_FLASH_LOCK_BIT = 1; // Write 1 to relock flash

  // Permanent failure clear sequence
  typedef enum logic [1:0] {
    PFC_IDLE,
    PFC_ARMED,
    PFC_LOCKOUT
  } gsc_pfc_t;

endpackage : gsc_pkg

// ===== verilog/gsc_control.sv
// Battery state encoder and manufacturer access control word interpreter.
// Assumes the SMBus layer hands over each decoded word write as a one-cycle
// pulse on the core clock and flags any other bus traffic as a pulse too.
`timescale 1ns/100ps

// Notes on behaviour
// [R01] State code in high byte low nibble
// [R02] Host sends words as manufacturer access writes
// [R03] Wake flag gives state zero
// [R04] Precharge without discharging gives three
// [R05] Maintenance charge without discharging gives seven
// [R06] Fast charge without discharging gives five
// [R07] Charge suspended, discharge allowed gives one
// [R08] Charge fault without discharging gives eight
// [R09] Short or overload, no overheat/overcurrent: C
// [R10] Discharge overcurrent either level gives a
// [R11] Pack absent gives f
// [R12] Sleep gives d; communication wakes
// [R13] Sealed device ignores every control word
// [R14] Shutdown word checks permission then shuts down
// [R15] Sleep word enters sleep
// [R16] Tracking word starts tracking, sets flags
// [R17] Update flags: only bit 2 used
// [R18] Clear pair clears failure, releases fuse, unlocks
// [R19] Broken pair fails; four second retry lockout
// [R20] Fuse blow drives pins active
// [R21] Fuse release if permitted, failure stays
// [R22] Leds forced on, or all off
// [R23] Display shows charge then times out
// [R24] Calibration word enters calibration
// [R25] Full reset word, clock stretched meanwhile
module gsc_control #(
  parameter int unsigned PF_RETRY_CYCLES = gsc_pkg::PF_RETRY_CYCLES,
  parameter int unsigned RESET_STRETCH_CYCLES = gsc_pkg::RESET_STRETCH_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [gsc_pkg::REG_AW-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Words from the SMBus layer
  input wire logic mac_write,
  input wire logic [15:0] mac_word,
  input wire logic bus_activity,
  // Gauge status flags
  input wire logic sealed_flag,
  input wire logic wake_flag,
  input wire logic pack_present_flag,
  input wire logic discharging_flag,
  input wire logic precharge_flag,
  input wire logic maintenance_charge_flag,
  input wire logic fast_charge_flag,
  input wire logic charge_suspended_flag,
  input wire logic discharge_disabled_flag,
  input wire logic discharge_inhibit_flag,
  input wire logic charge_overcurrent_flag,
  input wire logic charge_overvoltage_flag,
  input wire logic precharge_timeout_flag,
  input wire logic fast_charge_timeout_flag,
  input wire logic overcharge_flag,
  input wire logic low_voltage_charge_suspend,
  input wire logic charge_short_flag,
  input wire logic discharge_overload_flag,
  input wire logic discharge_short_flag,
  input wire logic discharge_overcurrent_flag,
  input wire logic discharge_overcurrent_tier2,
  input wire logic charge_overcurrent_safety,
  input wire logic charge_overtemp_flag,
  input wire logic discharge_overtemp_flag,
  input wire logic pf_detect,
  input wire logic [1:0] fet_state,
  input wire logic [1:0] pf_cause,
  input wire logic shutdown_permitted,
  input wire logic fuse_release_permitted,
  // Results
  output logic [15:0] mfg_status_word,
  output logic permanent_failure_flag,
  output logic shutdown_req,
  output logic sleep_active,
  output logic tracking_start,
  output logic voltage_ok_set,
  output logic capacity_update_set,
  output logic fuse_drive_n,
  output logic fuse_drive,
  output logic pf_clear_done,
  output logic flash_unlocked,
  output logic leds_force_on,
  output logic leds_off,
  output logic display_start,
  output logic calibration_active,
  output logic full_reset_req,
  output logic bus_clock_stretch
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  initial begin
    if (PF_RETRY_CYCLES < 1 || PF_RETRY_CYCLES >= (1 << 27)) begin
      $error("PF_RETRY_CYCLES out of range");
    end
    if (RESET_STRETCH_CYCLES < 1 || RESET_STRETCH_CYCLES >= (1 << 20)) begin
      $error("RESET_STRETCH_CYCLES out of range");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command decode

  // True when an unsealed word write carries the given code
  function automatic logic cmd_hit(input logic [15:0] code);
    cmd_hit = mac_write && !sealed_flag && (mac_word == code); // R13
  endfunction : cmd_hit

  logic [3:0] state_code; // Combinational state code
  logic [7:0] upd_flags_ff; // Update flags register
  gsc_pkg::gsc_pfc_t pfc_state_ff; // Clear sequence state
  gsc_pkg::gsc_pfc_t nxt_pfc_state;
  logic [26:0] retry_cnt_ff; // Lockout countdown
  logic [19:0] stretch_cnt_ff; // Full reset stretch countdown
  logic [15:0] rdata_ff; // Read data, one cycle after the strobe
  logic pf_ff, sleep_ff, fuse_n_ff, fuse_ff, unlock_ff; // Mode levels
  logic led_on_ff, cal_ff, stretch_ff; // More mode levels
  logic shutdown_ff, track_ff, leds_off_ff, display_ff, pf_done_ff, full_reset_ff; // Pulses
  logic ctrl_wr, retry_done, pair_ok, pair_fail; // Decode helpers

  assign ctrl_wr = reg_wr && (reg_addr == gsc_pkg::REG_CTRL);
  assign retry_done = (retry_cnt_ff == 27'h0000000);
  // Second code while armed completes the pair
  assign pair_ok = (pfc_state_ff == gsc_pkg::PFC_ARMED) && cmd_hit(gsc_pkg::CMD_PF_CLEAR_2); // R18
  // Anything else on the bus while armed spoils it
  assign pair_fail = (pfc_state_ff == gsc_pkg::PFC_ARMED)
                     && (bus_activity || (mac_write && !pair_ok)); // R19

  //////////////////////////////////////////////////////////////////////////////
  // State code encoder; priority runs from pack removed, sleep and failure down to plain discharge

  always_comb begin
    if (!pack_present_flag) begin
      state_code = gsc_pkg::ST_REMOVED; // R11
    end else if (sleep_ff) begin
      state_code = gsc_pkg::ST_SLEEP; // R12
    end else if (pf_ff) begin
      state_code = gsc_pkg::ST_PERM_FAIL;
    end else if (wake_flag) begin
      state_code = gsc_pkg::ST_WAKE; // R03
    end else if (charge_overtemp_flag) begin
      state_code = gsc_pkg::ST_CHG_OVERHEAT;
    end else if (discharge_overtemp_flag) begin
      state_code = gsc_pkg::ST_DEPLETED;
    end else if (discharge_overcurrent_flag || discharge_overcurrent_tier2) begin
      state_code = gsc_pkg::ST_DSG_OVERCURRENT; // R10
    end else if ((charge_short_flag || discharge_overload_flag || discharge_short_flag)
                 && !charge_overcurrent_safety) begin
      state_code = gsc_pkg::ST_SHORT_FAIL; // R09
    end else if (!discharging_flag && (charge_overcurrent_flag || charge_overvoltage_flag
                 || precharge_timeout_flag || fast_charge_timeout_flag
                 || overcharge_flag || low_voltage_charge_suspend)) begin
      state_code = gsc_pkg::ST_CHARGE_FAULT; // R08
    end else if ((discharge_disabled_flag || discharge_inhibit_flag) && discharging_flag) begin
      state_code = gsc_pkg::ST_DEPLETED;
    end else if (precharge_flag && !discharging_flag) begin
      state_code = gsc_pkg::ST_PRECHARGE; // R04
    end else if (maintenance_charge_flag && !discharging_flag) begin
      state_code = gsc_pkg::ST_MAINT_CHARGE; // R05
    end else if (fast_charge_flag && !discharging_flag) begin
      state_code = gsc_pkg::ST_FAST_CHARGE; // R06
    end else if (charge_suspended_flag && !discharge_disabled_flag
                 && !discharge_inhibit_flag) begin
      state_code = gsc_pkg::ST_DISCHARGE; // R07
    end else begin
      // Nothing matched: report plain discharge as the quiet state
      state_code = gsc_pkg::ST_DISCHARGE;
    end
  end

  // Status word: FET and failure cause above the state nibble
  assign mfg_status_word = {fet_state, pf_cause, state_code, gsc_pkg::MFG_STATUS_LOW}; // R01

  //////////////////////////////////////////////////////////////////////////////
  // Power modes

  // Sleep is left on any bus traffic, including any word write but an unsealed sleep word
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_ff <= 1'b0;
    end else if (cmd_hit(gsc_pkg::CMD_SLEEP)) begin
      sleep_ff <= 1'b1; // R15
    end else if (bus_activity || mac_write || stretch_ff) begin
      sleep_ff <= 1'b0; // R12
    end
  end

  // One-cycle command pulses; display timing itself lives in the LED driver
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {shutdown_ff, track_ff, pf_done_ff, leds_off_ff, display_ff, full_reset_ff} <= 6'h00;
    end else begin
      shutdown_ff <= cmd_hit(gsc_pkg::CMD_SHUTDOWN) && shutdown_permitted; // R14
      track_ff <= cmd_hit(gsc_pkg::CMD_TRACK_ENABLE); // R16
      pf_done_ff <= pair_ok; // R18
      leds_off_ff <= cmd_hit(gsc_pkg::CMD_LEDS_OFF); // R22
      display_ff <= cmd_hit(gsc_pkg::CMD_DISPLAY_ON); // R23
      full_reset_ff <= !stretch_ff && cmd_hit(gsc_pkg::CMD_FULL_RESET); // R25
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Tracking start and update flags

  // Only the tracking bit is stored; the command beats a same-cycle write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      upd_flags_ff <= gsc_pkg::UPD_RESET;
    end else if (stretch_ff) begin
      upd_flags_ff <= gsc_pkg::UPD_RESET;
    end else if (cmd_hit(gsc_pkg::CMD_TRACK_ENABLE)) begin
      upd_flags_ff[gsc_pkg::UPD_TRACK_BIT] <= 1'b1; // R16
    end else if (reg_wr && (reg_addr == gsc_pkg::REG_UPDATE_FLAGS)) begin
      upd_flags_ff[gsc_pkg::UPD_TRACK_BIT] <= reg_wdata[gsc_pkg::UPD_TRACK_BIT]; // R17
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Permanent failure clear sequence

  always_comb begin
    nxt_pfc_state = pfc_state_ff;
    case (pfc_state_ff)
      gsc_pkg::PFC_IDLE: begin
        if (cmd_hit(gsc_pkg::CMD_PF_CLEAR_1)) begin
          nxt_pfc_state = gsc_pkg::PFC_ARMED;
        end
      end
      gsc_pkg::PFC_ARMED: begin
        if (pair_ok) begin
          nxt_pfc_state = gsc_pkg::PFC_IDLE; // R18
        end else if (pair_fail) begin
          nxt_pfc_state = gsc_pkg::PFC_LOCKOUT; // R19
        end
      end
      gsc_pkg::PFC_LOCKOUT: begin
        // First code is ignored until the bus has been quiet long enough
        if (retry_done && !bus_activity && !mac_write) begin
          nxt_pfc_state = gsc_pkg::PFC_IDLE; // R19
        end
      end
      default: begin
        nxt_pfc_state = gsc_pkg::PFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pfc_state_ff <= gsc_pkg::PFC_IDLE;
    end else begin
      pfc_state_ff <= nxt_pfc_state;
    end
  end

  // Each communication during lockout restarts the quiet time
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      retry_cnt_ff <= 27'h0000000;
    end else if (pair_fail
                 || ((pfc_state_ff == gsc_pkg::PFC_LOCKOUT) && (bus_activity || mac_write))) begin
      retry_cnt_ff <= 27'(PF_RETRY_CYCLES - 1); // R19
    end else if (!retry_done) begin
      retry_cnt_ff <= retry_cnt_ff - 27'h0000001;
    end
  end

  // Failure flag: a detection in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pf_ff <= 1'b0;
    end else if (pf_detect) begin
      pf_ff <= 1'b1;
    end else if (pair_ok) begin
      pf_ff <= 1'b0; // R18
    end
  end

  // Flash stays unlocked until software relocks it or a full reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      unlock_ff <= 1'b0;
    end else if (pair_ok) begin
      unlock_ff <= 1'b1; // R18
    end else if (stretch_ff || (ctrl_wr && reg_wdata[gsc_pkg::CTRL_FLASH_LOCK_BIT])) begin
      unlock_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fuse drive pins; the pair always moves together

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fuse_n_ff <= 1'b1;
      fuse_ff <= 1'b0;
    end else if (cmd_hit(gsc_pkg::CMD_FUSE_BLOW)) begin
      fuse_n_ff <= 1'b0; // R20
      fuse_ff <= 1'b1;
    end else if (pair_ok
                 || (cmd_hit(gsc_pkg::CMD_FUSE_RELEASE) && fuse_release_permitted)) begin
      // Release leaves the failure flag alone
      fuse_n_ff <= 1'b1; // R21
      fuse_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // LED control

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      led_on_ff <= 1'b0;
    end else if (cmd_hit(gsc_pkg::CMD_LEDS_ON)) begin
      led_on_ff <= 1'b1; // R22
    end else if (cmd_hit(gsc_pkg::CMD_LEDS_OFF) || cmd_hit(gsc_pkg::CMD_DISPLAY_ON)
                 || stretch_ff) begin
      led_on_ff <= 1'b0; // R22
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Calibration and full reset

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_ff <= 1'b0;
    end else if (cmd_hit(gsc_pkg::CMD_CALIBRATE)) begin
      cal_ff <= 1'b1; // R24
    end else if (stretch_ff || (ctrl_wr && reg_wdata[gsc_pkg::CTRL_CAL_EXIT_BIT])) begin
      cal_ff <= 1'b0;
    end
  end

  // Stretch holds the bus clock low while the reset runs its course
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stretch_ff <= 1'b0;
      stretch_cnt_ff <= 20'h00000;
    end else if (!stretch_ff && cmd_hit(gsc_pkg::CMD_FULL_RESET)) begin
      stretch_ff <= 1'b1; // R25
      stretch_cnt_ff <= 20'(RESET_STRETCH_CYCLES - 1);
    end else if (stretch_ff) begin
      if (stretch_cnt_ff == 20'h00000) begin
        stretch_ff <= 1'b0; // R25
      end else begin
        stretch_cnt_ff <= stretch_cnt_ff - 20'h00001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register reads, one cycle after the strobe

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        gsc_pkg::REG_UPDATE_FLAGS: rdata_ff <= {8'h00, upd_flags_ff};
        gsc_pkg::REG_MFG_STATUS: rdata_ff <= mfg_status_word;
        gsc_pkg::REG_CTRL_STATUS: begin
          rdata_ff <= {6'h00, pfc_state_ff, stretch_ff, cal_ff, led_on_ff, unlock_ff,
                       fuse_ff, fuse_n_ff, sleep_ff, pf_ff};
        end
        default: rdata_ff <= 16'h0000;
      endcase
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata = rdata_ff;
  assign permanent_failure_flag = pf_ff;
  assign shutdown_req = shutdown_ff;
  assign sleep_active = sleep_ff;
  assign tracking_start = track_ff;
  assign voltage_ok_set = track_ff; // R16
  assign capacity_update_set = track_ff; // R16
  assign fuse_drive_n = fuse_n_ff;
  assign fuse_drive = fuse_ff;
  assign pf_clear_done = pf_done_ff;
  assign flash_unlocked = unlock_ff;
  assign leds_force_on = led_on_ff;
  assign leds_off = leds_off_ff;
  assign display_start = display_ff;
  assign calibration_active = cal_ff;
  assign full_reset_req = full_reset_ff;
  assign bus_clock_stretch = stretch_ff;

endmodule : gsc_control

// ===== verification/gsc_props.sv
// Checker on the control block ports.
// Assumes one core clock and an asynchronous active-low reset.
`timescale 1ns/100ps
module gsc_props #(
  parameter int unsigned PF_RETRY_CYCLES = 20,
  parameter int unsigned RESET_STRETCH_CYCLES = 8
) (
  input logic sys_clk,
  input logic reset_n,
  input logic mac_write,
  input logic [15:0] mac_word,
  input logic bus_activity,
  input logic sealed_flag,
  input logic pack_present_flag,
  input logic [1:0] fet_state,
  input logic [1:0] pf_cause,
  input logic shutdown_permitted,
  input logic [15:0] mfg_status_word,
  input logic permanent_failure_flag,
  input logic shutdown_req,
  input logic sleep_active,
  input logic tracking_start,
  input logic voltage_ok_set,
  input logic capacity_update_set,
  input logic fuse_drive_n,
  input logic fuse_drive,
  input logic pf_clear_done,
  input logic flash_unlocked,
  input logic leds_force_on,
  input logic leds_off,
  input logic display_start,
  input logic full_reset_req,
  input logic bus_clock_stretch
);
  default clocking dclk @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire uw = mac_write && !sealed_flag; // Unsealed word write
  wire [3:0] code = mfg_status_word[11:8]; // Reported state code
  logic [15:0] hi_ff; // Cycles of stretch so far
  ////////////////////////////////////////////////////////////////////////////////
  // Stretch length counter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_ff <= '0;
    end else begin
      hi_ff <= bus_clock_stretch ? hi_ff + 16'h1 : '0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_status_layout: assert property (mfg_status_word[7:0] == 8'h02 &&
    mfg_status_word[15:12] == {fet_state, pf_cause}) else $error("status layout");
  a_absent_code: assert property (!pack_present_flag |-> code == 4'hf)
    else $error("absent code");
  a_sleep_code: assert property (pack_present_flag && sleep_active |-> code == 4'hd)
    else $error("sleep code");
  a_bus_wakes: assert property (sleep_active && bus_activity |=> !sleep_active)
    else $error("sleep kept");
  a_sealed_idle: assert property (mac_write && sealed_flag |=>
    !(shutdown_req || tracking_start || full_reset_req) && $stable(fuse_drive))
    else $error("sealed acted");
  a_shutdown_check: assert property (uw && mac_word == 16'h0010 |=>
    shutdown_req == $past(shutdown_permitted)) else $error("shutdown");
  a_sleep_entry: assert property (uw && mac_word == 16'h0011 |=> sleep_active)
    else $error("sleep entry");
  a_track_flags: assert property (uw && mac_word == 16'h0021 |=>
    tracking_start && voltage_ok_set && capacity_update_set) else $error("tracking");
  a_clear_pair: assert property (pf_clear_done |-> flash_unlocked && fuse_drive_n &&
    !fuse_drive && $past(mac_word, 2) == 16'h2673 && $past(mac_word) == 16'h1712)
    else $error("clear pair");
  a_fuse_blow: assert property (uw && mac_word == 16'h0030 |=>
    !fuse_drive_n && fuse_drive) else $error("fuse blow");
  a_pf_kept: assert property (uw && mac_word == 16'h0031 && permanent_failure_flag |=>
    permanent_failure_flag) else $error("pf dropped");
  a_leds_dark: assert property (uw && mac_word == 16'h0033 |=>
    leds_off && !leds_force_on) else $error("leds off");
  a_display_go: assert property (uw && mac_word == 16'h0034 |=> display_start)
    else $error("display");
  a_stretch_len: assert property ($fell(bus_clock_stretch) && hi_ff != 16'h0 |->
    hi_ff == 16'(RESET_STRETCH_CYCLES)) else $error("stretch length");
  c_sleep: cover property (sleep_active ##1 !sleep_active);
  c_clear: cover property (pf_clear_done);
  c_stretch: cover property ($fell(bus_clock_stretch));
endmodule : gsc_props
bind gsc_control gsc_props #(.PF_RETRY_CYCLES(PF_RETRY_CYCLES),
  .RESET_STRETCH_CYCLES(RESET_STRETCH_CYCLES)) u_props (.*);

// ===== verification/gsc_host.sv
// Host model: word writes to manufacturer access and other bus traffic.
// Assumes one request a cycle on go or oth, raised after a clock edge.
`timescale 1ns/100ps
module gsc_host (
  input logic sys_clk,
  input logic reset_n,
  input logic go,
  input logic oth,
  input logic [15:0] wd,
  output logic mac_write,
  output logic bus_activity,
  output logic [15:0] mac_word
);
  // Idle word flips to the inverse of its previous value every cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {mac_write, bus_activity, mac_word} <= '0;
    end else begin
      mac_write <= go;
      bus_activity <= oth;
      mac_word <= go ? wd : ~mac_word;
    end
  end
endmodule : gsc_host

// ===== verification/testbench.sv
// Testbench: state code table, control words and register reads.
// Assumes design, checker and host model are compiled first.
`timescale 1ns/100ps
module testbench;
  logic sys_clk, reset_n, reg_wr, reg_rd, go, oth, rv, sealed_flag, pf_detect;
  logic shutdown_permitted, fuse_release_permitted, mac_write, bus_activity;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, wd, mac_word, reg_rdata, mfg_status_word;
  logic [1:0] fet_state, pf_cause;
  logic [19:0] q[$]; // Expected reads: index then value
  int failures, num_checks, cyc;
  logic permanent_failure_flag, shutdown_req, sleep_active, tracking_start, voltage_ok_set;
  logic capacity_update_set, fuse_drive_n, fuse_drive, pf_clear_done, flash_unlocked;
  logic leds_force_on, leds_off, display_start, calibration_active, full_reset_req;
  logic bus_clock_stretch;
  logic [22:0] f; // Gauge flags as one vector
  wire wake_flag = f[0], pack_present_flag = f[1], discharging_flag = f[2];
  wire precharge_flag = f[3], maintenance_charge_flag = f[4], fast_charge_flag = f[5];
  wire charge_suspended_flag = f[6], discharge_disabled_flag = f[7];
  wire discharge_inhibit_flag = f[8], charge_overcurrent_flag = f[9];
  wire charge_overvoltage_flag = f[10], precharge_timeout_flag = f[11];
  wire fast_charge_timeout_flag = f[12], overcharge_flag = f[13];
  wire low_voltage_charge_suspend = f[14], charge_short_flag = f[15];
  wire discharge_overload_flag = f[16], discharge_short_flag = f[17];
  wire discharge_overcurrent_flag = f[18], discharge_overcurrent_tier2 = f[19];
  wire charge_overcurrent_safety = f[20], charge_overtemp_flag = f[21];
  wire discharge_overtemp_flag = f[22];
  logic [22:0] tf [16] = '{23'h0, 23'h1, 23'h3, 23'ha, 23'he, 23'h12, 23'h22, 23'h46,
    23'hc6, 23'h202, 23'h4002, 23'h8002, 23'h10002, 23'h120002, 23'h40002, 23'h80002};
  logic [63:0] tc = 64'haa1c_c88e_1571_30ff; // State codes, entry 0 lowest
  // Short counts keep the run quick
  gsc_control #(.PF_RETRY_CYCLES(20), .RESET_STRETCH_CYCLES(8)) DUT (.*);
  gsc_host u_host (.*);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Read data stands one cycle after the strobe
  always @(posedge sys_clk) begin : watch
    logic [19:0] e;
    rv <= reg_rd;
    cyc++;
    if (rv === 1'b1) begin
      e = q.pop_front();
      num_checks++;
      if (reg_rdata !== e[15:0]) begin
        failures++;
        $display("[ERR] reg %h exp %h got %h", e[19:16], e[15:0], reg_rdata);
      end
    end
    if (cyc == 4000) begin
      failures++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  // Read expecting e, or write e when w is set
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input bit w = 0);
    reg_addr <= a;
    reg_wdata <= e;
    {reg_wr, reg_rd} <= {w, !w};
    if (!w) q.push_back({a, e});
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'b00;
    @(posedge sys_clk);
  endtask : rd
  // One word, or two back to back when two is set
  task automatic cmd(input logic [15:0] a, input logic [15:0] b = '0, input bit two = 0);
    go <= 1'b1;
    wd <= a;
    @(posedge sys_clk);
    if (two) begin
      wd <= b;
      @(posedge sys_clk);
    end
    go <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : cmd
  task automatic busy();
    oth <= 1'b1;
    @(posedge sys_clk);
    oth <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : busy
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, reg_wr, reg_rd, go, oth, sealed_flag, pf_detect} = '0;
    {shutdown_permitted, fuse_release_permitted} = 2'b11;
    {reg_addr, reg_wdata, wd, fet_state, pf_cause} = '0;
    f = 23'h2;
    void'($urandom(32'h82604bc2));
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(4'h0, 16'h0000);
    rd(4'h2, 16'h0004);
    for (int i = 0; i < 16; i++) begin
      f <= tf[i];
      {fet_state, pf_cause} <= 4'($urandom);
      @(posedge sys_clk);
      rd(4'h1, {fet_state, pf_cause, tc[4*i+:4], 8'h02});
    end
    f <= 23'h2;
    sealed_flag <= 1'b1;
    cmd(16'h0030);
    rd(4'h2, 16'h0004);
    sealed_flag <= 1'b0;
    cmd(16'h0030);
    rd(4'h2, 16'h0008);
    pf_detect <= 1'b1;
    @(posedge sys_clk);
    pf_detect <= 1'b0;
    fuse_release_permitted <= 1'b0;
    cmd(16'h0031);
    rd(4'h2, 16'h0009);
    fuse_release_permitted <= 1'b1;
    cmd(16'h0031);
    rd(4'h2, 16'h0005);
    cmd(16'h0030);
    cmd(16'h2673);
    rd(4'h2, 16'h0109);
    busy();
    cmd(16'h2673);
    rd(4'h2, 16'h0209);
    repeat (22) @(posedge sys_clk);
    rd(4'h2, 16'h0009);
    cmd(16'h2673, 16'h1712, 1);
    rd(4'h2, 16'h0014);
    cmd(16'h0011);
    rd(4'h2, 16'h0016);
    rd(4'h1, {fet_state, pf_cause, 4'hd, 8'h02});
    busy();
    rd(4'h2, 16'h0014);
    cmd(16'h0032);
    rd(4'h2, 16'h0034);
    cmd(16'h0033);
    cmd(16'h0034);
    cmd(16'h0040);
    rd(4'h2, 16'h0054);
    rd(4'h3, 16'h0003, 1);
    rd(4'h2, 16'h0004);
    cmd(16'h0021);
    rd(4'h0, 16'h0004);
    rd(4'h0, 16'hfffb, 1);
    rd(4'h0, 16'h0000);
    rd(4'h5, 16'hffff, 1);
    rd(4'h5, 16'h0000);
    shutdown_permitted <= 1'b0;
    cmd(16'h0010);
    shutdown_permitted <= 1'b1;
    cmd(16'h0010);
    cmd(16'h0041);
    rd(4'h2, 16'h0084);
    repeat (8) @(posedge sys_clk);
    rd(4'h2, 16'h0004);
    close_out();
  end
endmodule : testbench
